// File: src/gpc_pkg.sv
// constants, types and state layout for the adc control and touch override block
package gpc_pkg;

	// ---------------------------------------------------------------
	// register offsets on the internal register port
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_MAN_CTRL = 8'h51;
	localparam logic [7:0] OFS_AUTO_CTRL = 8'h52;
	localparam logic [7:0] OFS_RES_LOW = 8'h53;
	localparam logic [7:0] OFS_RES_HIGH = 8'h54;
	localparam logic [7:0] OFS_SUPPLY_RES = 8'h55;
	localparam logic [7:0] OFS_SUPPLY_THR = 8'h56;
	localparam logic [7:0] OFS_TOUCH_MODE = 8'h6A;
	localparam logic [7:0] OFS_TOUCH_DIRECT = 8'h6B;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int BIT_MAN_START = 4;
	localparam int BIT_AUTO_SUPPLY = 0;
	localparam int BIT_AUTO_AUX4 = 1;
	localparam int BIT_AUTO_AUX5 = 2;
	localparam int BIT_AUTO_AUX6 = 3;
	localparam int BIT_AUX4_ISRC = 4;
	localparam int BIT_BATTEMP_PERM = 5;
	localparam int BIT_FAST_SEQ = 6;
	localparam int BIT_COMP_EN = 7;
	localparam int BIT_TOUCH_AUTO = 0;
	localparam int BIT_TOUCH_OVR = 1;
	localparam int BIT_TOUCH_REF = 2;
	localparam int BIT_ROUTE_Y = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_WORD = 10'h000;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// ---------------------------------------------------------------
	// channel codes of the converter input multiplexer
	// ---------------------------------------------------------------
	localparam logic [3:0] CH_SUPPLY = 4'h0;
	localparam logic [3:0] CH_CHARGE = 4'h1;
	localparam logic [3:0] CH_BATTEMP = 4'h2;
	localparam logic [3:0] CH_BATTERY = 4'h3;
	localparam logic [3:0] CH_AUX4 = 4'h4;
	localparam logic [3:0] CH_AUX5 = 4'h5;
	localparam logic [3:0] CH_AUX6 = 4'h6;
	localparam logic [3:0] CH_TOUCH = 4'h7;
	localparam logic [3:0] CH_INT_TEMP = 4'h8;
	localparam logic [3:0] CH_BACKUP = 4'h9;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ = 40000;
	localparam int SEQ_FAST_US = 1000;
	localparam int SEQ_SLOW_US = 10000;
	localparam int SLOT_NS = 6000;
	localparam int SEQ_FAST_CYC = SEQ_FAST_US * CLK_KHZ / 1000;
	localparam int SEQ_SLOW_CYC = SEQ_SLOW_US * CLK_KHZ / 1000;
	localparam int SLOT_CYC_I = (SLOT_NS * CLK_KHZ + 999999) / 1000000;
	localparam logic [7:0] SLOT_CYC = 8'(SLOT_CYC_I);
	localparam logic [2:0] LAST_SLOT = 3'h4;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SCAN = 4'b0010,
		ST_PRE = 4'b0100,
		ST_WAIT = 4'b1000
	} gpc_state_e;

	typedef struct packed {
		logic [3:0] switches;
		logic [1:0] route;
		logic ref_sel;
	} gpc_touch_s;

	typedef struct packed {
		gpc_state_e st;
		logic [3:0] man_chan;
		logic man_start;
		logic [7:0] auto_ctrl;
		logic [7:0] touch_mode;
		gpc_touch_s touch_dir;
		logic [9:0] man_res;
		logic [7:0] supply_res;
		logic [7:0] supply_thr;
		logic [9:0] touch_x;
		logic [9:0] touch_y;
		logic seq_pend;
		logic [2:0] idx;
		logic cur_man;
		logic [7:0] wait_cnt;
		logic battery_temp_pin_slot;
		logic conv_start;
		logic [3:0] conv_chan;
		logic [7:0] rd_data;
		gpc_touch_s touch_out;
		logic battery_temp_pin_src;
		logic low_warn;
		logic [7:0] auto_res;
		logic [3:0] auto_chan;
		logic res_valid;
	} gpc_state_s;

endpackage

// File: src/gpc_control.sv
// adc channel control, auto sequencer, result registers and touch override
`timescale 1ns/1ps

// Function
// R1: override bit with touch auto off makes direct settings drive the panel.
// R2: four direct bits close X+, X-, Y+, Y- switches when one.
// R3: route 00 X+, 01 Y+, 10 X-, 11 Y-; results go to X or Y store.
// R4: reference bit zero uses touch reference and ground, one uses panel electrodes.
// R5: manual channel field bits 3:0 choose the conversion source.
// R6: writing one to bit 4 starts manual conversion; hardware clears it on completion.
// R7: auto control bits 0..3 enable supply, aux4, aux5, aux6 auto measurements.
// R8: auto control bit 4 switches the aux4 current source.
// R9: bit 5 zero pulses battery temp source one slot early; one keeps it on.
// R10: bit 6 picks 10 ms or 1 ms auto sequence interval.
// R11: auto control bit 7 enables the aux5 comparator.
// R12: manual result low two bits in low register, high eight in high register.
// R13: latest auto supply measurement kept as read-only 8-bit code.
// R14: writable 8-bit supply warning threshold on same scale as supply code.
// R15: touch auto enable hands the panel to the scheduling engine.
// R16: manual results written no later than the cycle the start bit clears.
module gpc_control
	import gpc_pkg::*;
#(
	parameter int SEQ_FAST_CYCLES = SEQ_FAST_CYC,
	parameter int SEQ_SLOW_CYCLES = SEQ_SLOW_CYC
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// converter handshake
	output logic conv_start,
	output logic [3:0] conv_channel,
	input wire logic conv_done,
	input wire logic [9:0] conv_data,
	// analog controls
	output logic aux4_current_source_enable,
	output logic battemp_source_on,
	output logic aux5_comparator_enable,
	output logic supply_low_warn,
	// auto results for the threshold logic outside
	output logic [7:0] auto_result,
	output logic [3:0] auto_result_chan,
	output logic auto_result_valid,
	// touch scheduler settings and panel controls
	input wire gpc_touch_s sched_touch,
	output logic touch_switch_xpos,
	output logic touch_switch_xneg,
	output logic touch_switch_ypos,
	output logic touch_switch_yneg,
	output logic [1:0] touch_pin_route,
	output logic conv_reference_select,
	// touch results of manual conversions
	output logic [9:0] touch_x_result,
	output logic [9:0] touch_y_result
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	localparam int CW = $clog2(SEQ_SLOW_CYCLES + 1);
	if (SEQ_FAST_CYCLES < 1 || SEQ_SLOW_CYCLES < SEQ_FAST_CYCLES)
	begin : g_bad_cycles
		$error("sequence interval counts out of range");
	end

	// the settle slot count must fit the 8-bit wait counter of the state
	if (SLOT_CYC_I < 1 || SLOT_CYC_I > 255)
	begin : g_bad_slot
		$error("settle slot count out of range");
	end

	// ---------------------------------------------------------------
	// slot helpers
	// ---------------------------------------------------------------
	// slot 0 is battery temp, always measured; the rest follow the enables
	function automatic logic slot_en(input logic [2:0] i, input logic [7:0] ac);
		case (i)
			3'h0: slot_en = 1'b1;
			3'h1: slot_en = ac[BIT_AUTO_SUPPLY]; // [R7]
			3'h2: slot_en = ac[BIT_AUTO_AUX4]; // [R7]
			3'h3: slot_en = ac[BIT_AUTO_AUX5]; // [R7]
			3'h4: slot_en = ac[BIT_AUTO_AUX6]; // [R7]
			default: slot_en = 1'b0;
		endcase
	endfunction

	function automatic logic [3:0] slot_chan(input logic [2:0] i);
		case (i)
			3'h0: slot_chan = CH_BATTEMP;
			3'h1: slot_chan = CH_SUPPLY;
			3'h2: slot_chan = CH_AUX4;
			3'h3: slot_chan = CH_AUX5;
			default: slot_chan = CH_AUX6;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	gpc_state_s s_ff;
	gpc_state_s nxt_s;
	logic [CW-1:0] seq_cnt_ff;
	logic [CW-1:0] nxt_seq_cnt;
	logic seq_tick;

	// interval timer, kept apart since its width follows the parameters
	always_comb
	begin
		seq_tick = (seq_cnt_ff == '0);
		if (seq_tick)
		begin
			if (s_ff.auto_ctrl[BIT_FAST_SEQ]) // [R10]
				nxt_seq_cnt = CW'(SEQ_FAST_CYCLES - 1);
			else
				nxt_seq_cnt = CW'(SEQ_SLOW_CYCLES - 1);
		end
		else
			nxt_seq_cnt = seq_cnt_ff - 1'b1;
	end

	// sequencer, register writes and output staging
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.conv_start = 1'b0;
		nxt_s.res_valid = 1'b0;
		case (s_ff.st)
			ST_IDLE:
			begin
				// manual requests only enter between sequences
				if (s_ff.man_start)
				begin
					nxt_s.cur_man = 1'b1;
					nxt_s.conv_chan = s_ff.man_chan; // [R5]
					nxt_s.conv_start = 1'b1; // [R6]
					nxt_s.st = ST_WAIT;
				end
				else if (s_ff.seq_pend)
				begin
					nxt_s.seq_pend = 1'b0;
					nxt_s.idx = 3'h0;
					nxt_s.st = ST_SCAN;
				end
			end
			ST_SCAN:
			begin
				if (s_ff.idx > LAST_SLOT)
					nxt_s.st = ST_IDLE;
				else if (slot_en(s_ff.idx, s_ff.auto_ctrl))
				begin
					nxt_s.cur_man = 1'b0;
					nxt_s.conv_chan = slot_chan(s_ff.idx);
					if (s_ff.idx == 3'h0 && !s_ff.auto_ctrl[BIT_BATTEMP_PERM])
					begin
						nxt_s.battery_temp_pin_slot = 1'b1; // [R9]
						nxt_s.wait_cnt = SLOT_CYC - 8'h01;
						nxt_s.st = ST_PRE;
					end
					else
					begin
						nxt_s.conv_start = 1'b1;
						nxt_s.st = ST_WAIT;
					end
				end
				else
					nxt_s.idx = s_ff.idx + 3'h1;
			end
			ST_PRE:
			begin
				// settling slot with the battery temp source already on
				if (s_ff.wait_cnt == 8'h00)
				begin
					nxt_s.conv_start = 1'b1;
					nxt_s.st = ST_WAIT;
				end
				else
					nxt_s.wait_cnt = s_ff.wait_cnt - 8'h01;
			end
			ST_WAIT:
			begin
				if (conv_done && s_ff.cur_man)
				begin
					nxt_s.man_res = conv_data; // [R16]
					nxt_s.man_start = 1'b0; // [R6]
					if (s_ff.conv_chan == CH_TOUCH)
					begin
						if (s_ff.touch_dir.route[BIT_ROUTE_Y]) // [R3]
							nxt_s.touch_y = conv_data;
						else
							nxt_s.touch_x = conv_data;
					end
					nxt_s.st = ST_IDLE;
				end
				else if (conv_done)
				begin
					// auto conversions keep only the 8 upper bits
					nxt_s.auto_res = conv_data[9:2];
					nxt_s.auto_chan = s_ff.conv_chan;
					nxt_s.res_valid = 1'b1;
					if (s_ff.conv_chan == CH_SUPPLY)
						nxt_s.supply_res = conv_data[9:2]; // [R13]
					nxt_s.battery_temp_pin_slot = 1'b0; // [R9]
					nxt_s.idx = s_ff.idx + 3'h1;
					nxt_s.st = ST_SCAN;
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase
		// interval tick after the fsm so a tick never gets lost
		if (seq_tick)
			nxt_s.seq_pend = 1'b1;
		// software writes last: a start written as hardware clears it wins
		if (reg_wr)
		begin
			case (reg_addr)
				OFS_MAN_CTRL:
				begin
					nxt_s.man_chan = reg_wdata[3:0]; // [R5]
					if (reg_wdata[BIT_MAN_START])
						nxt_s.man_start = 1'b1; // [R6]
				end
				OFS_AUTO_CTRL: nxt_s.auto_ctrl = reg_wdata;
				OFS_SUPPLY_THR: nxt_s.supply_thr = reg_wdata; // [R14]
				OFS_TOUCH_MODE: nxt_s.touch_mode = {5'h00, reg_wdata[2:0]};
				// direct byte: switches in bits 3:0, route in bits 5:4
				OFS_TOUCH_DIRECT:
					nxt_s.touch_dir = {reg_wdata[3:0], reg_wdata[5:4], s_ff.touch_dir.ref_sel};
				default: nxt_s.touch_mode = nxt_s.touch_mode;
			endcase
			if (reg_addr == OFS_TOUCH_MODE)
				nxt_s.touch_dir.ref_sel = reg_wdata[BIT_TOUCH_REF]; // [R4]
		end
		// panel control source, switches open when neither mode owns it
		if (s_ff.touch_mode[BIT_TOUCH_AUTO])
			nxt_s.touch_out = sched_touch; // [R15]
		else if (s_ff.touch_mode[BIT_TOUCH_OVR])
			nxt_s.touch_out = s_ff.touch_dir; // [R1]
		else
			nxt_s.touch_out = '0;
		nxt_s.battery_temp_pin_src = nxt_s.auto_ctrl[BIT_BATTEMP_PERM] | nxt_s.battery_temp_pin_slot; // [R9]
		// warning compares codes directly, both share one linear scale
		nxt_s.low_warn = (s_ff.supply_res < s_ff.supply_thr); // [R14]
		// read data registered: one cycle latency after the address
		case (reg_addr)
			OFS_MAN_CTRL: nxt_s.rd_data = {3'h0, s_ff.man_start, s_ff.man_chan};
			OFS_AUTO_CTRL: nxt_s.rd_data = s_ff.auto_ctrl;
			OFS_RES_LOW: nxt_s.rd_data = {6'h00, s_ff.man_res[1:0]}; // [R12]
			OFS_RES_HIGH: nxt_s.rd_data = s_ff.man_res[9:2]; // [R12]
			OFS_SUPPLY_RES: nxt_s.rd_data = s_ff.supply_res; // [R13]
			OFS_SUPPLY_THR: nxt_s.rd_data = s_ff.supply_thr;
			OFS_TOUCH_MODE: nxt_s.rd_data = {5'h00, s_ff.touch_dir.ref_sel, s_ff.touch_mode[1:0]};
			// readback mirrors the written layout of the direct byte
			OFS_TOUCH_DIRECT: nxt_s.rd_data = {2'h0, s_ff.touch_dir.route, s_ff.touch_dir.switches};
			default: nxt_s.rd_data = RD_UNMAPPED;
		endcase
	end

	// all state but the interval timer in one register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_ff <= '0;
			// the enum field needs its one-hot idle code, not all zeros
			s_ff.st <= ST_IDLE;
			seq_cnt_ff <= '0;
		end
		else
		begin
			s_ff <= nxt_s;
			seq_cnt_ff <= nxt_seq_cnt;
		end
	end

	// ---------------------------------------------------------------
	// outputs, each straight from the state register
	// ---------------------------------------------------------------
	assign reg_rdata = s_ff.rd_data;
	assign conv_start = s_ff.conv_start;
	assign conv_channel = s_ff.conv_chan;
	assign aux4_current_source_enable = s_ff.auto_ctrl[BIT_AUX4_ISRC]; // [R8]
	assign battemp_source_on = s_ff.battery_temp_pin_src;
	assign aux5_comparator_enable = s_ff.auto_ctrl[BIT_COMP_EN]; // [R11]
	assign supply_low_warn = s_ff.low_warn;
	assign auto_result = s_ff.auto_res;
	assign auto_result_chan = s_ff.auto_chan;
	assign auto_result_valid = s_ff.res_valid;
	// switch order in the struct: xpos, xneg, ypos, yneg from bit 0 up
	assign touch_switch_xpos = s_ff.touch_out.switches[0]; // [R2]
	assign touch_switch_xneg = s_ff.touch_out.switches[1]; // [R2]
	assign touch_switch_ypos = s_ff.touch_out.switches[2]; // [R2]
	assign touch_switch_yneg = s_ff.touch_out.switches[3]; // [R2]
	assign touch_pin_route = s_ff.touch_out.route; // [R3]
	assign conv_reference_select = s_ff.touch_out.ref_sel; // [R4]
	assign touch_x_result = s_ff.touch_x;
	assign touch_y_result = s_ff.touch_y;

endmodule

// File: sim/gpc_control_properties.sv
// port-level property checker for the adc control block
`timescale 1ns/1ps
module gpc_control_properties
	import gpc_pkg::*;
(
	// clock, reset, register port
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	// converter and analog controls
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [9:0] conv_data,
	input wire logic aux4_current_source_enable,
	input wire logic battemp_source_on,
	input wire logic aux5_comparator_enable,
	input wire logic supply_low_warn,
	input wire logic [7:0] auto_result,
	input wire logic [3:0] auto_result_chan,
	input wire logic auto_result_valid,
	// touch panel
	input wire gpc_touch_s sched_touch,
	input wire logic touch_switch_xpos,
	input wire logic touch_switch_xneg,
	input wire logic touch_switch_ypos,
	input wire logic touch_switch_yneg,
	input wire logic [1:0] touch_pin_route,
	input wire logic conv_reference_select
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [7:0] ac_ff, md_ff, dr_ff, thr_ff, sup_ff;
	logic [1:0] age_ff;
	gpc_touch_s st_ff;
	logic [6:0] pan;
	assign pan = {touch_switch_yneg, touch_switch_ypos, touch_switch_xneg, touch_switch_xpos,
		touch_pin_route, conv_reference_select};
	// shadows of written settings; age counts quiet cycles so latency never matters
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ac_ff <= 8'h00;
			md_ff <= 8'h00;
			dr_ff <= 8'h00;
			thr_ff <= 8'h00;
			sup_ff <= 8'h00;
			age_ff <= 2'h0;
			st_ff <= '0;
		end
		else
		begin
			st_ff <= sched_touch;
			if (reg_wr && reg_addr == OFS_AUTO_CTRL)
				ac_ff <= reg_wdata;
			if (reg_wr && reg_addr == OFS_TOUCH_MODE)
				md_ff <= reg_wdata;
			if (reg_wr && reg_addr == OFS_TOUCH_DIRECT)
				dr_ff <= reg_wdata;
			if (reg_wr && reg_addr == OFS_SUPPLY_THR)
				thr_ff <= reg_wdata;
			if (auto_result_valid && auto_result_chan == CH_SUPPLY)
				sup_ff <= auto_result;
			if (reg_wr || auto_result_valid || sched_touch != st_ff)
				age_ff <= 2'h0;
			else if (age_ff != 2'h3)
				age_ff <= age_ff + 2'h1;
		end
	end
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	aux4_source_a: assert property (age_ff == 2'h3 |-> aux4_current_source_enable == ac_ff[4])
		else $error("aux4 source wrong");
	battemp_perm_a: assert property (age_ff == 2'h3 && ac_ff[5] |-> battemp_source_on)
		else $error("battery temp source off");
	battemp_pre_a: assert property (age_ff == 2'h3 && !ac_ff[5] && $rose(battemp_source_on)
		|-> ##[230:250] conv_start) else $error("no conversion after settle");
	comp_enable_a: assert property (age_ff == 2'h3 |-> aux5_comparator_enable == ac_ff[7])
		else $error("comparator enable wrong");
	touch_auto_a: assert property (age_ff == 2'h3 && md_ff[0] |-> pan == st_ff)
		else $error("scheduler not driving panel");
	touch_override_a: assert property (age_ff == 2'h3 && md_ff[1:0] == 2'b10
		|-> pan == {dr_ff[3:0], dr_ff[5:4], md_ff[2]}) else $error("override wrong");
	touch_idle_a: assert property (age_ff == 2'h3 && md_ff[1:0] == 2'b00 |-> pan == 7'h00)
		else $error("panel driven while idle");
	auto_result_a: assert property (auto_result_valid |-> $past(conv_done) &&
		auto_result == $past(conv_data[9:2])) else $error("auto result wrong");
	low_warn_a: assert property (age_ff == 2'h3 |-> supply_low_warn == (sup_ff < thr_ff))
		else $error("low warning wrong");
	start_pulse_a: assert property (conv_start || conv_done |=> !conv_start)
		else $error("start too close");
	cover property (auto_result_valid && auto_result_chan == CH_SUPPLY);
	cover property (age_ff == 2'h3 && md_ff[1:0] == 2'b10);
	cover property (age_ff == 2'h3 && md_ff[0]);
endmodule

bind gpc_control gpc_control_properties gpc_control_properties_inst (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .conv_start(conv_start),
	.conv_done(conv_done), .conv_data(conv_data),
	.aux4_current_source_enable(aux4_current_source_enable),
	.battemp_source_on(battemp_source_on), .aux5_comparator_enable(aux5_comparator_enable),
	.supply_low_warn(supply_low_warn), .auto_result(auto_result),
	.auto_result_chan(auto_result_chan), .auto_result_valid(auto_result_valid),
	.sched_touch(sched_touch), .touch_switch_xpos(touch_switch_xpos),
	.touch_switch_xneg(touch_switch_xneg), .touch_switch_ypos(touch_switch_ypos),
	.touch_switch_yneg(touch_switch_yneg), .touch_pin_route(touch_pin_route),
	.conv_reference_select(conv_reference_select));

// File: sim/tb_top.sv
// self-checking bench for the adc control and touch override block
`timescale 1ns/1ps
module tb_top;
	import gpc_pkg::*;
	localparam int FAST = 2000;
	localparam int SLOW = 4000;
	logic clk, rst_n, reg_wr, conv_start, conv_done, arv, a4, bt, cp, warn, xp, xn, yp, yn, rf;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, ares, rv;
	logic [3:0] conv_channel, achan;
	logic [9:0] conv_data, tx, ty;
	logic [1:0] route;
	logic [6:0] tv;
	gpc_touch_s sched_touch;
	int error_cnt, checks_done, i, k;
	int mdl [256];
	int cdat [16];

	gpc_control #(.SEQ_FAST_CYCLES(FAST), .SEQ_SLOW_CYCLES(SLOW)) gpc_control_inst (.clk, .rst_n,
		.reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .conv_start, .conv_channel, .conv_done,
		.conv_data, .aux4_current_source_enable(a4), .battemp_source_on(bt),
		.aux5_comparator_enable(cp), .supply_low_warn(warn), .auto_result(ares),
		.auto_result_chan(achan), .auto_result_valid(arv), .sched_touch,
		.touch_switch_xpos(xp), .touch_switch_xneg(xn), .touch_switch_ypos(yp),
		.touch_switch_yneg(yn), .touch_pin_route(route), .conv_reference_select(rf),
		.touch_x_result(tx), .touch_y_result(ty));

	// clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// converter stand-in; data lines flip after done so stale values never match
	initial
	begin
		conv_done = 1'b0;
		conv_data = 10'h000;
		forever
		begin
			@(posedge clk);
			#1;
			if (conv_start === 1'b1)
			begin
				repeat (3 + $urandom % 6) @(posedge clk);
				#2 conv_done = 1'b1;
				conv_data = cdat[conv_channel];
				@(posedge clk);
				#2 conv_done = 1'b0;
				conv_data = ~conv_data;
			end
		end
	end

	task automatic cmp(input logic [9:0] g, input logic [9:0] e, input string m);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// register write; model keeps what a readback should show
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#2 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#2 reg_wr = 1'b0;
		case (a)
			OFS_MAN_CTRL: mdl[a] = d & 8'h0F;
			OFS_AUTO_CTRL, OFS_SUPPLY_THR: mdl[a] = d;
			OFS_TOUCH_MODE: mdl[a] = d & 8'h07;
			OFS_TOUCH_DIRECT: mdl[a] = d & 8'h3F;
			default: ;
		endcase
	endtask

	task automatic get(input logic [7:0] a);
		@(posedge clk);
		#2 reg_addr = a;
		@(posedge clk);
		#1 rv = reg_rdata;
	endtask

	task automatic rd(input logic [7:0] a, input string m);
		get(a);
		cmp(rv, mdl[a][7:0], m);
	endtask

	task automatic tch(input logic [6:0] e);
		repeat (2) @(posedge clk);
		#3 tv = {yn, yp, xn, xp, route, rf};
		cmp(tv, e, "panel");
	endtask

	// waits for the next stored supply result, k holds the cycles waited
	task automatic sup_wait;
		k = 0;
		do
		begin
			@(posedge clk);
			#1 k++;
		end
		while (!(arv === 1'b1 && achan === CH_SUPPLY) && k < 20000);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog, well beyond the planned run
	initial
	begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		close_out;
	end

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h5FF9));
		error_cnt = 0;
		checks_done = 0;
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		sched_touch = '0;
		for (i = 0; i < 16; i++)
			cdat[i] = $urandom % 1024;
		cdat[0] = 256 + $urandom % 512;
		repeat (6) @(posedge clk);
		#2 rst_n = 1'b1;
		// reset values, read-only and unmapped places
		wr(OFS_SUPPLY_RES, 8'($urandom));
		wr(8'h57, 8'hA5);
		for (i = 8'h50; i < 8'h58; i++)
			rd(i[7:0], "reset map");
		for (i = 0; i < 12; i++)
		begin
			k = (i % 4 == 0) ? OFS_MAN_CTRL : (i % 4 == 1) ? OFS_AUTO_CTRL : (i % 4 == 2) ?
				OFS_SUPPLY_THR : OFS_TOUCH_DIRECT;
			wr(k[7:0], 8'($urandom) & ((k == OFS_MAN_CTRL) ? 8'hEF : 8'hFF));
			rd(k[7:0], "readback");
		end
		$display("test regs done");
		// direct panel control over all routes, then scheduler, then idle
		for (i = 0; i < 8; i++)
		begin
			k = (i % 4) * 16 + $urandom % 16;
			wr(OFS_TOUCH_DIRECT, k[7:0]);
			wr(OFS_TOUCH_MODE, {5'h00, i[2], 2'b10});
			tch({k[3:0], k[5:4], i[2]});
			rd(OFS_TOUCH_MODE, "mode readback");
		end
		wr(OFS_TOUCH_MODE, 8'h03);
		sched_touch = 7'($urandom);
		tch(sched_touch);
		wr(OFS_TOUCH_MODE, 8'h00);
		tch(7'h00);
		$display("test touch done");
		// manual conversion on every channel
		wr(OFS_AUTO_CTRL, 8'h40);
		wr(OFS_TOUCH_DIRECT, 8'h10);
		for (i = 0; i < 10; i++)
		begin
			wr(OFS_MAN_CTRL, 8'h10 | i[7:0]);
			rv = 8'h10;
			for (k = 0; k < 2000 && rv[4] !== 1'b0; k++)
				get(OFS_MAN_CTRL);
			cmp(rv, i[9:0], "start bit");
			mdl[OFS_RES_LOW] = cdat[i] % 4;
			mdl[OFS_RES_HIGH] = cdat[i] / 4;
			rd(OFS_RES_LOW, "result low");
			rd(OFS_RES_HIGH, "result high");
		end
		cmp(ty, cdat[7][9:0], "touch y");
		// route X- now, with fresh data so the Y store must keep its value
		cdat[7] = 1023 - cdat[7];
		wr(OFS_TOUCH_DIRECT, 8'h20);
		wr(OFS_MAN_CTRL, 8'h17);
		rv = 8'h10;
		for (k = 0; k < 2000 && rv[4] !== 1'b0; k++)
			get(OFS_MAN_CTRL);
		cmp(tx, cdat[7][9:0], "touch x");
		cmp(ty, 10'(1023 - cdat[7]), "touch y kept");
		$display("test manual done");
		// automatic supply result, threshold warning and intervals
		wr(OFS_AUTO_CTRL, 8'hCF);
		sup_wait;
		cmp(ares, cdat[0][9:2], "supply code");
		mdl[OFS_SUPPLY_RES] = cdat[0] / 4;
		rd(OFS_SUPPLY_RES, "supply reg");
		wr(OFS_SUPPLY_THR, 8'(cdat[0] / 4 + 1));
		repeat (4) @(posedge clk);
		#1 cmp(warn, 1'b1, "warn set");
		wr(OFS_SUPPLY_THR, 8'(cdat[0] / 4));
		repeat (4) @(posedge clk);
		#1 cmp(warn, 1'b0, "warn clear");
		sup_wait;
		cmp(10'(k > FAST - 100 && k < FAST + 100), 10'h001, "fast gap");
		wr(OFS_AUTO_CTRL, 8'h8F);
		sup_wait;
		sup_wait;
		sup_wait;
		cmp(10'(k > SLOW - 100 && k < SLOW + 100), 10'h001, "slow gap");
		$display("test auto done");
		close_out;
	end
endmodule
